//--- logic/cdss_regs.vh
// register offsets, control fields, reset values and timing counts of the servo supervisor
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus
`ifndef CDSS_REGS_VH
`define CDSS_REGS_VH
// ===========================================
// clock and timing
`define CDSS_CLK_HZ 100000000
`define CDSS_FAST_TPS 1200
`define CDSS_FAST_CYC (`CDSS_CLK_HZ / `CDSS_FAST_TPS)
`define CDSS_SLOW_HZ 12000
`define CDSS_SLOW_CYC (`CDSS_CLK_HZ / `CDSS_SLOW_HZ)
`define CDSS_FOCUS_LOST_US 3000
`define CDSS_FOCUS_LOST_CYC (`CDSS_FOCUS_LOST_US * (`CDSS_CLK_HZ / 1000000))
`define CDSS_SQ_HALF_NS 250
`define CDSS_SQ_HALF_CYC ((`CDSS_SQ_HALF_NS * (`CDSS_CLK_HZ / 1000000)) / 1000)
`define CDSS_PDM_LO_HZ 1058400
`define CDSS_PDM_HI_HZ 2116800
`define CDSS_NCO_LO ((64'd`CDSS_PDM_LO_HZ << 24) / 64'd`CDSS_CLK_HZ)
`define CDSS_NCO_HI ((64'd`CDSS_PDM_HI_HZ << 24) / 64'd`CDSS_CLK_HZ)
`define CDSS_JUMP_MIN_TRACKS 16'h0004
`define CDSS_DISC_FRAMES 24'h00_000A
// ===========================================
// register word offsets, matched against ADR_I[7:2]
`define CDSS_OFS_CTRL 6'h00
`define CDSS_OFS_MASK 6'h01
`define CDSS_OFS_HLS 6'h02
`define CDSS_OFS_TRACKS 6'h03
`define CDSS_OFS_DEFECT 6'h04
`define CDSS_OFS_PLAYTIME 6'h05
`define CDSS_OFS_JUMPTIME 6'h06
`define CDSS_OFS_TIMER 6'h07
// ===========================================
// control register fields
`define CDSS_C_RADIAL 0
`define CDSS_C_SLEDGE 1
`define CDSS_C_MOTOR 2
`define CDSS_C_JUMP 3
`define CDSS_C_EXT_LONG 4
`define CDSS_C_PLAY_WD 5
`define CDSS_C_JUMP_WD 6
`define CDSS_C_TIMER 7
`define CDSS_C_LASER 8
`define CDSS_C_PDM_FAST 9
`define CDSS_C_DEC_IF 10
`define CDSS_C_FOUR_WIRE 11
`define CDSS_C_DEFECT_LO 12
`define CDSS_C_LSTEP_LO 14
`define CDSS_C_STAT_IRQ 16
`define CDSS_C_STAT_OFS 17
`define CDSS_C_DSEL_LO 19
`define CDSS_C_MJUMP 22
`define CDSS_CTRL_RESET 32'h0000_0000
`define CDSS_CTRL_MASK 32'h007F_FFFF
`define CDSS_MASK_RESET 32'h0000_0000
`endif

//--- logic/cdss_pdm.v
// first-order pulse density modulator for one actuator drive channel
// assumes a rate tick from the parent; level is unsigned, all ones gives near full density
`timescale 1ns/10ps
`default_nettype none
module cdss_pdm #(
	parameter W = 8
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire tick_i,
	input wire [W-1:0] level_i,
	output reg bit_o
);
	// ===========================================
	// accumulator
	reg [W:0] acc_reg;

	// carry out of the accumulator is the density bit
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			acc_reg <= {(W+1){1'b0}};
			bit_o <= 1'b0;
		end else if (tick_i) begin
			acc_reg <= {1'b0, acc_reg[W-1:0]} + {1'b0, level_i};
			bit_o <= acc_reg[W];
		end
	end
endmodule
`default_nettype wire

//--- logic/cdss_wdt.v
// restartable timeout counter used by watchdogs and the timer tick
// assumes run and kick come from the same clock; a zero limit never fires
`timescale 1ns/10ps
`default_nettype none
module cdss_wdt #(
	parameter W = 24
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire run_i,
	input wire kick_i,
	input wire [W-1:0] limit_i,
	output reg fire_o
);
	// ===========================================
	// counter
	reg [W-1:0] cnt_reg;

	// one-cycle fire when the count reaches the limit, then count again
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt_reg <= {W{1'b0}};
			fire_o <= 1'b0;
		end else if (!run_i || kick_i || limit_i == {W{1'b0}}) begin
			cnt_reg <= {W{1'b0}};
			fire_o <= 1'b0;
		end else if (cnt_reg == limit_i - {{(W-1){1'b0}}, 1'b1}) begin
			cnt_reg <= {W{1'b0}};
			fire_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
			fire_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- logic/cdss_top.v
// servo supervisor: off-track counting, defect gating, interrupts, watchdogs, drive and laser
// assumes a classic wishbone master on CLK_I; pin inputs arrive asynchronously
// Function
// - above 1200 tracks/s select fast state, decrement counter only on polarity events
// - slow state: direction from polarity phase at track loss, one track per pulse
// - fast state reverts to slow when crossing rate falls below 12 kHz
// - choose protected, slow or fast counting state internally
// - track position flag marks spot within a quarter pitch of track
// - defect detector off, focus, or focus and radial zeroes errors; set point programmable
// - off-track flag valid while tracking and counter nonzero
// - counter reset after 0.75 track in short mode, at origin in long mode
// - status pin shows interrupt, decoder status or offset; interrupt selection wins
// - decoder status mode shows selected decoder bit active low, four-wire only
// - eight maskable interrupt sources
// - discontinuity when new subcode time earlier or over 10 frames later
// - high-level status read returns status, clears interrupts, re-enables subcode reads
// - decoder status pin follows selector rewrites and decoder interface enable
// - focus watchdog: 3 ms dropout sets focus lost, stops radial, sledge, motor
// - play watchdog after first frame; frame gap timeout sets radial error, motor jump
// - jump watchdog: under 4 tracks per interval flags error, stops servos
// - radial watchdogs enabled individually; focus watchdog always on
// - timer interrupts with programmable period when sequencers unused
// - drives pulse density modulated at 1.0584 or 2.1168 MHz
// - drives high impedance in reset; laser off gives 2 MHz square on radial, focus
// - laser on by control or active focus loop; four power steps
`include "cdss_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module cdss_top #(
	parameter FAST_CYC = `CDSS_FAST_CYC,
	parameter SLOW_CYC = `CDSS_SLOW_CYC,
	parameter FOCUS_LOST_CYC = `CDSS_FOCUS_LOST_CYC,
	parameter LW = 8
) (
	input wire CLK_I,
	input wire RST_B_I,
	input wire [7:0] ADR_I,
	input wire [31:0] DAT_I,
	output reg [31:0] DAT_O,
	input wire WE_I,
	input wire [3:0] SEL_I,
	input wire CYC_I,
	input wire STB_I,
	output reg ACK_O,
	input wire TRACK_POSITION_FLAG_I,
	input wire RADIAL_POLARITY_FLAG_I,
	input wire TRACK_LOSS_SIGNAL_I,
	input wire FOCUS_OK_I,
	input wire [7:0] DEFECT_LEVEL_I,
	input wire [11:0] FOCUS_ERR_I,
	input wire [11:0] RADIAL_ERR_I,
	output reg [11:0] FOCUS_ERR_O,
	output reg [11:0] RADIAL_ERR_O,
	input wire SUBCODE_FRAME_I,
	input wire [23:0] SUBCODE_TIME_I,
	input wire [7:0] SUBCODE_SEC_I,
	input wire SUBQ_READY_I,
	input wire SEQ_STATE_CHG_I,
	input wire SEQ_ERR_I,
	input wire DEC_IF_BUSY_I,
	input wire [7:0] SEQ_STATUS_I,
	input wire [7:0] DEC_STATUS_I,
	input wire [7:0] MOTOR_START_TIME_I,
	input wire OFFSET_INFO_I,
	input wire FOCUS_LOOP_ACTIVE_I,
	input wire [LW-1:0] RADIAL_LEVEL_I,
	input wire [LW-1:0] FOCUS_LEVEL_I,
	input wire [LW-1:0] SLEDGE_LEVEL_I,
	output reg RADIAL_DRIVE_OUT_O,
	output reg RADIAL_DRIVE_OE_O,
	output reg FOCUS_DRIVE_OUT_O,
	output reg FOCUS_DRIVE_OE_O,
	output reg SLEDGE_DRIVE_OUT_O,
	output reg SLEDGE_DRIVE_OE_O,
	output reg LASER_ON_O,
	output reg [1:0] LASER_STEP_O,
	output reg STATUS_O,
	output reg IRQ_O,
	output reg TRACK_ON_O,
	output reg OFF_TRACK_O,
	output reg SUBQ_READ_EN_O,
	output wire RADIAL_SERVO_EN_O,
	output wire SLEDGE_SERVO_EN_O,
	output wire MOTOR_DRIVE_EN_O,
	output wire MOTOR_JUMP_O
);
	// ===========================================
	// functions
	// merge write data into a register under the byte enables
	function [31:0] wb_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] sel;
		integer k;
		begin
			wb_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					wb_merge[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	localparam ST_PROT = 2'd0;
	localparam ST_SLOW = 2'd1;
	localparam ST_FAST = 2'd2;

	// ===========================================
	// pin synchronisers
	wire [3:0] pin_raw = {FOCUS_OK_I, TRACK_LOSS_SIGNAL_I, RADIAL_POLARITY_FLAG_I, TRACK_POSITION_FLAG_I};
	reg [3:0] pin_s1_reg;
	reg [3:0] pin_s2_reg;
	reg [3:0] pin_d_reg;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			// two flops per pin, a third for edge detection
			always @(posedge CLK_I) begin
				if (!RST_B_I) begin
					pin_s1_reg[g] <= 1'b0;
					pin_s2_reg[g] <= 1'b0;
					pin_d_reg[g] <= 1'b0;
				end else begin
					pin_s1_reg[g] <= pin_raw[g];
					pin_s2_reg[g] <= pin_s1_reg[g];
					pin_d_reg[g] <= pin_s2_reg[g];
				end
			end
		end
	endgenerate
	wire track_position_flag = pin_s2_reg[0];
	wire tpi_rise = pin_s2_reg[0] & ~pin_d_reg[0];
	wire rp = pin_s2_reg[1];
	wire rp_rise = pin_s2_reg[1] & ~pin_d_reg[1];
	wire tl_rise = pin_s2_reg[2] & ~pin_d_reg[2];
	wire focus_ok = pin_s2_reg[3];

	// ===========================================
	// registers and bus
	reg [31:0] ctrl_reg;
	reg [31:0] ctrl_next;
	reg [7:0] mask_reg;
	reg [7:0] defect_reg;
	reg [15:0] play_reg;
	reg [15:0] jtime_reg;
	reg [15:0] timer_reg;
	reg [7:0] int_reg;
	reg [7:0] int_next;
	reg [7:0] int_set;
	reg [31:0] rd_data;
	wire req = CYC_I & STB_I & ~ACK_O;
	wire wr = req & WE_I;
	wire [5:0] idx = ADR_I[7:2];
	wire hls_read = req & ~WE_I & (idx == `CDSS_OFS_HLS);
	wire trk_write = wr & (idx == `CDSS_OFS_TRACKS);

	// track counting state
	reg [1:0] st_reg;
	reg [1:0] st_next;
	reg [15:0] cnt_reg;
	reg [15:0] cnt_next;
	reg dir_out_reg;
	reg [19:0] per_reg;
	reg ext_pend_reg;
	// byte-lane merges of the 16-bit registers, the empty upper half is cut off
	wire [31:0] cnt_wr = wb_merge({16'h0000, cnt_reg}, DAT_I, SEL_I);
	wire [31:0] play_wr = wb_merge({16'h0000, play_reg}, DAT_I, SEL_I);
	wire [31:0] jtime_wr = wb_merge({16'h0000, jtime_reg}, DAT_I, SEL_I);
	wire [31:0] timer_wr = wb_merge({16'h0000, timer_reg}, DAT_I, SEL_I);

	// watchdog and timer fires
	wire focus_fire;
	wire play_fire;
	wire jump_tick;
	wire timer_fire;
	reg first_frame_reg;
	reg [15:0] jsample_reg;
	wire jump_err = jump_tick & ((jsample_reg - cnt_reg) < `CDSS_JUMP_MIN_TRACKS);

	// read multiplexer
	always @* begin
		case (idx)
			`CDSS_OFS_CTRL: rd_data = ctrl_reg;
			`CDSS_OFS_MASK: rd_data = {24'h00_0000, mask_reg};
			`CDSS_OFS_HLS: rd_data = {MOTOR_START_TIME_I, SEQ_STATUS_I, DEC_STATUS_I, int_reg};
			`CDSS_OFS_TRACKS: rd_data = {13'h0000, dir_out_reg, st_reg, cnt_reg};
			`CDSS_OFS_DEFECT: rd_data = {24'h00_0000, defect_reg};
			`CDSS_OFS_PLAYTIME: rd_data = {16'h0000, play_reg};
			`CDSS_OFS_JUMPTIME: rd_data = {16'h0000, jtime_reg};
			`CDSS_OFS_TIMER: rd_data = {16'h0000, timer_reg};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// one-cycle acknowledge, unmapped reads return zero
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= req;
			DAT_O <= req ? rd_data : 32'h0000_0000;
		end
	end

	// control next value: software write, then watchdog actions override
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr && idx == `CDSS_OFS_CTRL) begin
			ctrl_next = wb_merge(ctrl_reg, DAT_I, SEL_I) & `CDSS_CTRL_MASK;
		end
		if (focus_fire) begin
			ctrl_next[`CDSS_C_RADIAL] = 1'b0;
			ctrl_next[`CDSS_C_SLEDGE] = 1'b0;
			ctrl_next[`CDSS_C_MOTOR] = 1'b0;
		end
		if (play_fire) begin
			ctrl_next[`CDSS_C_RADIAL] = 1'b0;
			ctrl_next[`CDSS_C_SLEDGE] = 1'b0;
			ctrl_next[`CDSS_C_MJUMP] = 1'b1;
		end
		if (jump_err) begin
			ctrl_next[`CDSS_C_RADIAL] = 1'b0;
			ctrl_next[`CDSS_C_SLEDGE] = 1'b0;
			ctrl_next[`CDSS_C_JUMP] = 1'b0;
		end
	end

	// software-written registers
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			ctrl_reg <= `CDSS_CTRL_RESET;
			mask_reg <= 8'h00;
			defect_reg <= 8'h00;
			play_reg <= 16'h0000;
			jtime_reg <= 16'h0000;
			timer_reg <= 16'h0000;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr && idx == `CDSS_OFS_MASK && SEL_I[0])
				mask_reg <= DAT_I[7:0];
			if (wr && idx == `CDSS_OFS_DEFECT && SEL_I[0])
				defect_reg <= DAT_I[7:0];
			if (wr && idx == `CDSS_OFS_PLAYTIME)
				play_reg <= play_wr[15:0];
			if (wr && idx == `CDSS_OFS_JUMPTIME)
				jtime_reg <= jtime_wr[15:0];
			if (wr && idx == `CDSS_OFS_TIMER)
				timer_reg <= timer_wr[15:0];
		end
	end
	assign RADIAL_SERVO_EN_O = ctrl_reg[`CDSS_C_RADIAL];
	assign SLEDGE_SERVO_EN_O = ctrl_reg[`CDSS_C_SLEDGE];
	assign MOTOR_DRIVE_EN_O = ctrl_reg[`CDSS_C_MOTOR];
	assign MOTOR_JUMP_O = ctrl_reg[`CDSS_C_MJUMP];
	wire jumping = ctrl_reg[`CDSS_C_JUMP];
	wire tracking = ctrl_reg[`CDSS_C_RADIAL];

	// ===========================================
	// counting state and off-track counter
	wire [1:0] dmode = ctrl_reg[`CDSS_C_DEFECT_LO +: 2];
	wire defect = (DEFECT_LEVEL_I > defect_reg) & (dmode != 2'd0);
	wire cnt_edge = (st_reg == ST_FAST) ? rp_rise : tl_rise;

	// state selection from jump request and crossing period
	always @* begin
		st_next = st_reg;
		case (st_reg)
			ST_PROT: begin
				if (jumping)
					st_next = ST_SLOW;
			end
			ST_SLOW: begin
				if (!jumping)
					st_next = ST_PROT;
				else if (tl_rise && per_reg < FAST_CYC)
					st_next = ST_FAST;
			end
			ST_FAST: begin
				if (!jumping)
					st_next = ST_PROT;
				else if (per_reg > SLOW_CYC)
					st_next = ST_SLOW;
			end
			default: st_next = ST_PROT;
		endcase
	end

	// counter: signed offset while protected, tracks to go while jumping
	always @* begin
		cnt_next = cnt_reg;
		if (trk_write) begin
			cnt_next = cnt_wr[15:0];
		end else if (st_reg == ST_PROT) begin
			if (tl_rise && !defect)
				cnt_next = rp ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
			if (ctrl_reg[`CDSS_C_EXT_LONG] ? (tpi_rise && cnt_reg == 16'h0000) : (tpi_rise && ext_pend_reg))
				cnt_next = 16'h0000;
		end else if (cnt_edge && cnt_reg != 16'h0000) begin
			cnt_next = cnt_reg - 16'h0001;
		end
	end

	// state, counter, period and direction flops
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			st_reg <= ST_PROT;
			cnt_reg <= 16'h0000;
			per_reg <= 20'h0_0000;
			dir_out_reg <= 1'b0;
			ext_pend_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			if (cnt_edge)
				per_reg <= 20'h0_0000;
			else if (per_reg != 20'hF_FFFF)
				per_reg <= per_reg + 20'h0_0001;
			if (st_reg == ST_SLOW && tl_rise)
				dir_out_reg <= rp;
			ext_pend_reg <= (st_reg == ST_PROT) & (cnt_next != 16'h0000) & ~(tpi_rise & ext_pend_reg);
		end
	end

	// ===========================================
	// watchdogs and timer
	cdss_wdt #(.W(24)) u_focus_wd (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.run_i(~focus_ok),
		.kick_i(focus_ok),
		.limit_i(FOCUS_LOST_CYC[23:0]),
		.fire_o(focus_fire)
	);
	cdss_wdt #(.W(24)) u_play_wd (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.run_i(ctrl_reg[`CDSS_C_PLAY_WD] & tracking & ~jumping & first_frame_reg),
		.kick_i(SUBCODE_FRAME_I),
		.limit_i({play_reg, 8'h00}),
		.fire_o(play_fire)
	);
	cdss_wdt #(.W(24)) u_jump_wd (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.run_i(ctrl_reg[`CDSS_C_JUMP_WD] & jumping),
		.kick_i(1'b0),
		.limit_i({jtime_reg, 8'h00}),
		.fire_o(jump_tick)
	);
	cdss_wdt #(.W(24)) u_timer (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.run_i(ctrl_reg[`CDSS_C_TIMER]),
		.kick_i(1'b0),
		.limit_i({timer_reg, 8'h00}),
		.fire_o(timer_fire)
	);

	// first frame arming and jump sampling
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			first_frame_reg <= 1'b0;
			jsample_reg <= 16'h0000;
		end else begin
			if (!tracking || jumping)
				first_frame_reg <= 1'b0;
			else if (SUBCODE_FRAME_I)
				first_frame_reg <= 1'b1;
			if (!jumping || jump_tick)
				jsample_reg <= cnt_next;
		end
	end

	// ===========================================
	// interrupt status
	reg [23:0] prev_time_reg;
	reg [7:0] prev_sec_reg;
	reg have_time_reg;
	wire disc = have_time_reg & ((SUBCODE_TIME_I < prev_time_reg) |
		(SUBCODE_TIME_I > prev_time_reg + `CDSS_DISC_FRAMES));

	// event sources in mask bit order
	always @* begin
		int_set = 8'h00;
		int_set[0] = focus_fire;
		int_set[1] = SUBQ_READY_I;
		int_set[2] = SUBCODE_FRAME_I & have_time_reg & (SUBCODE_SEC_I != prev_sec_reg);
		int_set[3] = SUBCODE_FRAME_I & disc;
		int_set[4] = play_fire | jump_err;
		int_set[5] = SEQ_STATE_CHG_I | timer_fire;
		int_set[6] = SEQ_ERR_I;
		int_set[7] = DEC_IF_BUSY_I;
		int_next = (hls_read ? 8'h00 : int_reg) | int_set;
	end

	// sticky status, subcode history and read enable
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			int_reg <= 8'h00;
			prev_time_reg <= 24'h00_0000;
			prev_sec_reg <= 8'h00;
			have_time_reg <= 1'b0;
			SUBQ_READ_EN_O <= 1'b1;
			IRQ_O <= 1'b0;
		end else begin
			int_reg <= int_next;
			IRQ_O <= |(int_next & mask_reg);
			if (SUBCODE_FRAME_I) begin
				prev_time_reg <= SUBCODE_TIME_I;
				prev_sec_reg <= SUBCODE_SEC_I;
				have_time_reg <= 1'b1;
			end
			if (hls_read)
				SUBQ_READ_EN_O <= 1'b1;
			else if (DEC_IF_BUSY_I)
				SUBQ_READ_EN_O <= 1'b0;
		end
	end

	// ===========================================
	// drive outputs and laser
	reg [23:0] nco_reg;
	reg [4:0] sq_cnt_reg;
	reg sq_reg;
	wire [63:0] inc_lo = `CDSS_NCO_LO;
	wire [63:0] inc_hi = `CDSS_NCO_HI;
	wire [23:0] nco_inc = ctrl_reg[`CDSS_C_PDM_FAST] ? inc_hi[23:0] : inc_lo[23:0];
	wire [24:0] nco_sum = {1'b0, nco_reg} + {1'b0, nco_inc};
	wire [3*LW-1:0] lvl = {SLEDGE_LEVEL_I, FOCUS_LEVEL_I, RADIAL_LEVEL_I};
	wire [2:0] pdm_bit;
	wire laser_on = ctrl_reg[`CDSS_C_LASER] | FOCUS_LOOP_ACTIVE_I;
	wire [31:0] sq_half = `CDSS_SQ_HALF_CYC - 1;
	wire [4:0] sq_last = sq_half[4:0];

	// rate generator and 2 MHz square
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			nco_reg <= 24'h00_0000;
			sq_cnt_reg <= 5'h00;
			sq_reg <= 1'b0;
		end else begin
			nco_reg <= nco_sum[23:0];
			if (sq_cnt_reg == sq_last) begin
				sq_cnt_reg <= 5'h00;
				sq_reg <= ~sq_reg;
			end else begin
				sq_cnt_reg <= sq_cnt_reg + 5'h01;
			end
		end
	end

	generate
		for (g = 0; g < 3; g = g + 1) begin : g_pdm
			cdss_pdm #(.W(LW)) u_pdm (
				.clk_i(CLK_I),
				.rst_b_i(RST_B_I),
				.tick_i(nco_sum[24]),
				.level_i(lvl[g*LW +: LW]),
				.bit_o(pdm_bit[g])
			);
		end
	endgenerate

	// pin flops: enables low in reset, square on radial and focus while laser off
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			RADIAL_DRIVE_OUT_O <= 1'b0;
			FOCUS_DRIVE_OUT_O <= 1'b0;
			SLEDGE_DRIVE_OUT_O <= 1'b0;
			RADIAL_DRIVE_OE_O <= 1'b0;
			FOCUS_DRIVE_OE_O <= 1'b0;
			SLEDGE_DRIVE_OE_O <= 1'b0;
			LASER_ON_O <= 1'b0;
			LASER_STEP_O <= 2'b00;
		end else begin
			RADIAL_DRIVE_OUT_O <= laser_on ? pdm_bit[0] : sq_reg;
			FOCUS_DRIVE_OUT_O <= laser_on ? pdm_bit[1] : sq_reg;
			SLEDGE_DRIVE_OUT_O <= pdm_bit[2];
			RADIAL_DRIVE_OE_O <= 1'b1;
			FOCUS_DRIVE_OE_O <= 1'b1;
			SLEDGE_DRIVE_OE_O <= 1'b1;
			LASER_ON_O <= laser_on;
			LASER_STEP_O <= ctrl_reg[`CDSS_C_LSTEP_LO +: 2];
		end
	end

	// ===========================================
	// status pin, error gating, track flags
	wire [2:0] dsel = ctrl_reg[`CDSS_C_DSEL_LO +: 3];
	wire dec_bit = ctrl_reg[`CDSS_C_DEC_IF] ? DEC_IF_BUSY_I : DEC_STATUS_I[dsel];

	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			STATUS_O <= 1'b1;
			FOCUS_ERR_O <= 12'h000;
			RADIAL_ERR_O <= 12'h000;
			TRACK_ON_O <= 1'b0;
			OFF_TRACK_O <= 1'b0;
		end else begin
			if (ctrl_reg[`CDSS_C_STAT_IRQ])
				STATUS_O <= |(int_reg & mask_reg);
			else if (ctrl_reg[`CDSS_C_STAT_OFS])
				STATUS_O <= OFFSET_INFO_I;
			else if (ctrl_reg[`CDSS_C_FOUR_WIRE])
				STATUS_O <= ~dec_bit;
			else
				STATUS_O <= 1'b1;
			FOCUS_ERR_O <= defect ? 12'h000 : FOCUS_ERR_I;
			RADIAL_ERR_O <= (defect && dmode == 2'd2) ? 12'h000 : RADIAL_ERR_I;
			TRACK_ON_O <= track_position_flag;
			OFF_TRACK_O <= tracking & (cnt_reg != 16'h0000);
		end
	end
endmodule
`default_nettype wire

//--- bench/cdss_chk_sva.sv
// bus timing, reset and drive checks on the supervisor ports
// assumes it is bound onto cdss_top by the statement at the foot
`timescale 1ns/10ps
`default_nettype none
module cdss_chk (
	input wire CLK_I,
	input wire RST_B_I,
	input wire CYC_I,
	input wire STB_I,
	input wire WE_I,
	input wire ACK_O,
	input wire [31:0] DAT_O,
	input wire RADIAL_DRIVE_OE_O,
	input wire FOCUS_DRIVE_OE_O,
	input wire SLEDGE_DRIVE_OE_O,
	input wire STATUS_O,
	input wire FOCUS_LOOP_ACTIVE_I,
	input wire LASER_ON_O,
	input wire RADIAL_SERVO_EN_O,
	input wire RADIAL_DRIVE_OUT_O,
	input wire TRACK_POSITION_FLAG_I,
	input wire TRACK_ON_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	// ====================
	// square low phase ending, then the high phase
	sequence sq_low;
		(!RADIAL_DRIVE_OUT_O && !LASER_ON_O) [*8] ##1 (RADIAL_DRIVE_OUT_O && !LASER_ON_O);
	endsequence
	sequence sq_high;
		(RADIAL_DRIVE_OUT_O || LASER_ON_O) [*8];
	endsequence
	ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
	ack_delay_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
	dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000) else $error("read data without ack");
	hiz_reset_a: assert property (disable iff (1'b0) !RST_B_I |=>
		!(RADIAL_DRIVE_OE_O || FOCUS_DRIVE_OE_O || SLEDGE_DRIVE_OE_O) && STATUS_O) else $error("drive in reset");
	laser_auto_a: assert property (FOCUS_LOOP_ACTIVE_I [*3] |-> LASER_ON_O) else $error("laser off");
	servo_write_a: assert property ($rose(RADIAL_SERVO_EN_O) |->
		$past(CYC_I) && $past(STB_I) && $past(WE_I) && !$past(ACK_O)) else $error("servo on without write");
	square_half_a: assert property (sq_low |=> sq_high) else $error("square high phase short");
	track_flag_a: assert property (TRACK_POSITION_FLAG_I [*4] |-> TRACK_ON_O) else $error("track flag lost");
endmodule
bind cdss_top cdss_chk u_cdss_chk (.*);
`default_nettype wire

//--- bench/cdss_disc.sv
// disc model: track loss and polarity pins for three crossings
// assumes go pulses one cycle; dir high means an outward jump
`timescale 1ns/10ps
`default_nettype none
module cdss_disc (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic dir_i,
	output logic tl_o,
	output logic rp_o
);
	logic [5:0] cnt_reg = 6'h00;
	logic [1:0] left_reg = 2'h0;
	// one crossing each 16 cycles
	always @(posedge clk_i) begin
		if (go_i) begin
			left_reg <= 2'h3;
			cnt_reg <= 6'h00;
		end else if (left_reg != 2'h0) begin
			cnt_reg <= cnt_reg + 6'h01;
			if (cnt_reg[3:0] == 4'hF) left_reg <= left_reg - 2'h1;
		end
	end
	// polarity a quarter crossing ahead of track loss when outward
	assign tl_o = (left_reg != 2'h0) && cnt_reg[3];
	assign rp_o = cnt_reg[3] ^ cnt_reg[2] ^ ~dir_i;
endmodule
`default_nettype wire

//--- bench/cdss_top_bench.sv
// self-checking bench of the servo supervisor with a disc model
// assumes shortened counts; host traffic over classic wishbone
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module cdss_top_bench;
	logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, track_position_flag = 0, fok = 1, frm = 0, sqr = 0, fla = 0, go = 0, dir = 1;
	logic ofs = 0;
	logic s0;
	logic [3:0] sel = 4'h0;
	logic [7:0] adr = 8'h00, dl = 8'h00, lev = 8'h00;
	logic [11:0] fe = 12'h000, re = 12'h000;
	logic [23:0] stime = 24'h00_0000, st = 24'h00_0000;
	logic [31:0] wd = 32'h0000_0000, q;
	logic [23:0] tm [3] = '{24'h00_006E, 24'h00_0079, 24'h00_0078};
	logic [7:0] de [3] = '{8'h00, 8'h0C, 8'h08};
	wire [31:0] dato;
	wire [11:0] feo, reo;
	wire [1:0] lstep;
	wire ack, tl, rp, rdo, roe, foe, soe, lon, stat, irq, oft, rsen;
	int err_count = 0, n_checks = 0, seed = 32'h5e54, cyc_n = 0, i, k;
	cdss_top #(.FAST_CYC(200), .SLOW_CYC(50), .FOCUS_LOST_CYC(100)) u_cdss_top (
		.CLK_I(clk), .RST_B_I(rst_b), .ADR_I(adr), .DAT_I(wd), .DAT_O(dato), .WE_I(we), .SEL_I(sel),
		.CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .TRACK_POSITION_FLAG_I(track_position_flag), .RADIAL_POLARITY_FLAG_I(rp),
		.TRACK_LOSS_SIGNAL_I(tl), .FOCUS_OK_I(fok), .DEFECT_LEVEL_I(dl), .FOCUS_ERR_I(fe), .RADIAL_ERR_I(re),
		.FOCUS_ERR_O(feo), .RADIAL_ERR_O(reo), .SUBCODE_FRAME_I(frm), .SUBCODE_TIME_I(stime),
		.SUBCODE_SEC_I({4'h0, stime[7:4]}), .SUBQ_READY_I(sqr), .SEQ_STATE_CHG_I(1'b0), .SEQ_ERR_I(sqr),
		.DEC_IF_BUSY_I(1'b0),
		.SEQ_STATUS_I(st[15:8]), .DEC_STATUS_I(st[7:0]), .MOTOR_START_TIME_I(st[23:16]), .OFFSET_INFO_I(ofs),
		.FOCUS_LOOP_ACTIVE_I(fla), .RADIAL_LEVEL_I(lev), .FOCUS_LEVEL_I(lev), .SLEDGE_LEVEL_I(lev),
		.RADIAL_DRIVE_OUT_O(rdo), .RADIAL_DRIVE_OE_O(roe), .FOCUS_DRIVE_OUT_O(), .FOCUS_DRIVE_OE_O(foe),
		.SLEDGE_DRIVE_OUT_O(), .SLEDGE_DRIVE_OE_O(soe), .LASER_ON_O(lon), .LASER_STEP_O(lstep), .STATUS_O(stat),
		.IRQ_O(irq), .TRACK_ON_O(), .OFF_TRACK_O(oft), .SUBQ_READ_EN_O(), .RADIAL_SERVO_EN_O(rsen),
		.SLEDGE_SERVO_EN_O(), .MOTOR_DRIVE_EN_O(), .MOTOR_JUMP_O());
	cdss_disc u_cdss_disc (.clk_i(clk), .go_i(go), .dir_i(dir), .tl_o(tl), .rp_o(rp));
	// ====================
	// tasks: waits, bus cycle, status read, subcode frame, verdict
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		adr <= a;
		we <= w;
		wd <= d;
		sel <= 4'hF;
		cyc <= 1;
		stb <= 1;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dato;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic hls(input logic [7:0] e);
		wb(8'h08, 0, 0);
		`CHK("hls", {st, e}, q)
	endtask
	task automatic frame(input logic [23:0] t);
		stime <= t;
		frm <= 1;
		tk(1);
		frm <= 0;
		tk(2);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ====================
	// clock and hang limit
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			err_count++;
			stop_test;
		end
	end
	// main sequence
	initial begin
		tk(2);
		rst_b <= 1;
		lev <= $random(seed);
		st <= $random(seed);
		tk(2);
		`CHK("oe", 3'b111, {roe, foe, soe})
		for (i = 0; i < 3; i++) begin
			k = $random(seed);
			wb(8'h00, 1, k);
			wb(8'h00, 0, 0);
			`CHK("ctrl", k & 32'h007F_FFFF, q)
		end
		wb(8'hF0, 1, 32'hFFFF_FFFF);
		wb(8'hF0, 0, 0);
		`CHK("unmapped", 32'h0000_0000, q)
		// subcode ready unmasked then masked, pin on interrupt
		wb(8'h00, 1, 32'h0001_0000);
		for (i = 0; i < 2; i++) begin
			wb(8'h04, 1, i ? 0 : 2);
			wb(8'h08, 0, 0);
			s0 = stat;
			sqr <= 1;
			tk(1);
			sqr <= 0;
			tk(3);
			`CHK("irq", ~i[0], irq)
			`CHK("pin", s0 ^ ~i[0], stat)
			hls(8'h42);
			tk(1);
			`CHK("irq clr", 1'b0, irq)
		end
		// subcode time ten later, eleven later, then earlier
		frame(24'h00_0064);
		wb(8'h08, 0, 0);
		for (i = 0; i < 3; i++) begin
			frame(tm[i]);
			hls(de[i]);
		end
		// defect gating for each mode, level above then below set point
		wb(8'h10, 1, 32'h0000_0040);
		for (i = 0; i < 3; i++) begin
			wb(8'h00, 1, i << 12);
			fe <= $random(seed);
			re <= $random(seed);
			dl <= 8'h80 | $random(seed);
			tk(4);
			`CHK("fe", i > 0 ? 12'h000 : fe, feo)
			`CHK("re", i > 1 ? 12'h000 : re, reo)
			dl <= 8'h10;
			tk(4);
			`CHK("fe pass", fe, feo)
		end
		// protected counting out three then in three
		wb(8'h00, 1, 32'h0000_0001);
		for (i = 0; i < 2; i++) begin
			dir <= ~i[0];
			go <= 1;
			tk(1);
			go <= 0;
			tk(60);
			wb(8'h0C, 0, 0);
			`CHK("tracks", i ? 18'h0_0000 : 18'h0_0003, q[17:0])
			`CHK("off", ~i[0], oft)
		end
		// jump: slow, fast on quick crossings, back to slow
		wb(8'h0C, 1, 32'h0000_0040);
		wb(8'h00, 1, 32'h0000_0009);
		wb(8'h0C, 0, 0);
		`CHK("slow", 2'h1, q[17:16])
		go <= 1;
		tk(1);
		go <= 0;
		tk(46);
		wb(8'h0C, 0, 0);
		`CHK("fast", 2'h2, q[17:16])
		`CHK("dir", 1'b0, q[18])
		tk(60);
		wb(8'h0C, 0, 0);
		`CHK("slow again", 2'h1, q[17:16])
		// focus dropout past the shortened limit
		wb(8'h00, 1, 32'h0000_0007);
		fok <= 0;
		tk(120);
		fok <= 1;
		`CHK("servo", 1'b0, rsen)
		hls(8'h01);
		// laser step, automatic laser, square with laser off
		wb(8'h00, 1, 32'h0000_8100);
		tk(2);
		`CHK("laser", 3'b110, {lon, lstep})
		wb(8'h00, 1, 32'h0000_0000);
		fla <= 1;
		tk(3);
		`CHK("laser auto", 1'b1, lon)
		fla <= 0;
		tk(3);
		k = 0;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			k += rdo;
		end
		`CHK("square", 50, k)
		// decoder status bit, then offset, then interrupt priority on the pin
		wb(8'h00, 1, 32'h0000_0800);
		`CHK("dec bit", ~st[0], stat)
		wb(8'h00, 1, 32'h0008_0800);
		`CHK("dec sel", ~st[1], stat)
		wb(8'h00, 1, 32'h0002_0000);
		ofs <= 1;
		tk(2);
		`CHK("offset", 1'b1, stat)
		wb(8'h00, 1, 32'h0003_0000);
		`CHK("irq first", 1'b0, stat)
		track_position_flag <= 1;
		tk(6);
		track_position_flag <= 0;
		tk(2);
		wb(8'h0C, 0, 0);
		`CHK("ext clr", 16'h0000, q[15:0])
		stop_test;
	end
endmodule
`default_nettype wire
